// [fss_defines.vh]
// register map, field positions and reset values of the fast serial port
`ifndef FSS_DEFINES_VH
`define FSS_DEFINES_VH

`define FSS_OFF_CTRL        16'hC060
`define FSS_OFF_DIVISOR     16'hC064
`define FSS_OFF_STATUS      16'hC068
`define FSS_OFF_TXDATA      16'hC06C
`define FSS_OFF_RXDATA      16'hC070
`define FSS_OFF_GAP         16'hC074
`define FSS_OFF_IRQ_STAT    16'hC078
`define FSS_OFF_IRQ_MASK    16'hC07C
`define FSS_OFF_BLK_ADDR    16'hC080

`define FSS_CTRL_FLOW_EN    0
`define FSS_CTRL_TX_BLOCK   1
`define FSS_CTRL_RX_BLOCK   2

`define FSS_ST_RX_AVAIL     0
`define FSS_ST_TX_BUSY      1
`define FSS_ST_TX_PEND      2

`define FSS_EV_RX_DONE      0
`define FSS_EV_TX_DONE      1
`define FSS_EV_RX_OVFL      2
`define FSS_EV_FRAME_ERR    3

`define FSS_CTRL_RST        3'h0
`define FSS_DIVISOR_RST     16'h0017
`define FSS_GAP_RST         16'h000B
`define FSS_GAP_BIAS        16'h0009
`define FSS_DATA_BITS       4'h8
`define FSS_RTS_DROP_BIT    4'h2

`endif

// [fss_rx_fifo.v]
// receive character fifo held in flip-flops
`timescale 1ns/1ps
`default_nettype none
module fss_rx_fifo #(
  parameter WIDTH = 8,
  parameter AW    = 4
) (
  input  wire             clk_i,
  input  wire             rst_i,
  input  wire             push_i,
  input  wire [WIDTH-1:0] push_data_i,
  input  wire             pop_i,
  output wire [WIDTH-1:0] pop_data_o,
  output wire             full_o,
  output wire             empty_o
);
  localparam DEPTH = 1 << AW;

  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_r;
  reg [AW-1:0]    rd_ptr_r;
  reg [AW:0]      count_r;
  wire            do_push;
  wire            do_pop;

  assign full_o     = (count_r == DEPTH[AW:0]);
  assign empty_o    = (count_r == {(AW+1){1'b0}});
  assign do_push    = push_i & ~full_o;
  assign do_pop     = pop_i & ~empty_o;
  assign pop_data_o = mem_r[rd_ptr_r];

  always @(posedge clk_i) begin
    if (do_push) begin
      mem_r[wr_ptr_r] <= push_data_i;
    end
  end

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r  <= {(AW+1){1'b0}};
    end else begin
      if (do_push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      if (do_push & ~do_pop) begin
        count_r <= count_r + 1'b1;
      end else if (do_pop & ~do_push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// [fss_serial_port.v]
// fast serial port: avalon register slave, transmitter, receiver, block memory writes
//
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "fss_defines.vh"
module fss_serial_port #(
  parameter FIFO_AW = 4
) (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire [15:0] avs_address_i,
  input  wire        avs_read_i,
  input  wire        avs_write_i,
  input  wire [31:0] avs_writedata_i,
  input  wire [3:0]  avs_byteenable_i,
  output reg  [31:0] avs_readdata_o,
  output reg         avs_waitrequest_o,
  output reg         irq_o,
  input  wire        serial_rx_line_i,
  output reg         serial_tx_line_o,
  input  wire        clear_to_send_in_i,
  output reg         request_to_send_out_o,
  output reg         mem_wr_o,
  output reg  [15:0] mem_addr_o,
  output reg  [7:0]  mem_wdata_o
);
  localparam T_IDLE  = 5'b00001;
  localparam T_WAIT  = 5'b00010;
  localparam T_START = 5'b00100;
  localparam T_DATA  = 5'b01000;
  localparam T_STOP  = 5'b10000;
  localparam R_IDLE  = 4'b0001;
  localparam R_START = 4'b0010;
  localparam R_DATA  = 4'b0100;
  localparam R_STOP  = 4'b1000;
  function hit;
    input [15:0] a;
    input [15:0] off;
    hit = (a == off);
  endfunction
  function [15:0] merge16;
    input [15:0] old;
    input [15:0] nw;
    input [1:0]  be;
    merge16 = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
  endfunction
  reg  [2:0]  ctrl_r;
  reg  [15:0] div_r;
  reg  [15:0] gap_r;
  reg  [15:0] blk_addr_r;
  reg  [3:0]  irq_stat_r;
  reg  [3:0]  irq_mask_r;
  reg  [7:0]  tx_hold_r;
  reg         tx_pend_r;
  reg  [4:0]  tx_state_r;
  reg  [15:0] tx_cnt_r;
  reg  [3:0]  tx_bit_r;
  reg  [15:0] tx_stop_r;
  reg  [7:0]  tx_shift_r;
  reg  [3:0]  rx_state_r;
  reg  [15:0] rx_cnt_r;
  reg  [3:0]  rx_bit_r;
  reg  [7:0]  rx_shift_r;
  reg         rx_s1_r;
  reg         rx_s2_r;
  reg         rx_s3_r;
  reg         rx_done_r;
  reg         rx_ferr_r;
  reg         tx_done_r;
  reg  [31:0] rd_nxt;
  reg  [3:0]  ev_nxt;
  wire        acc_done;
  wire        wr_done;
  wire [15:0] wlo;
  wire [1:0]  wbe;
  wire        fifo_full;
  wire        fifo_empty;
  wire [7:0]  fifo_data;
  wire        fifo_push;
  wire        fifo_pop;
  wire        tx_tick;
  wire        rx_tick;
  wire [15:0] blk_stop;
  assign acc_done = (avs_read_i | avs_write_i) & ~avs_waitrequest_o;
  assign wr_done  = avs_write_i & ~avs_waitrequest_o;
  assign wlo      = avs_writedata_i[15:0];
  assign wbe      = avs_byteenable_i[1:0];
  assign tx_tick  = (tx_cnt_r == 16'h0000);
  assign rx_tick  = (rx_cnt_r == 16'h0000);
  assign blk_stop = (gap_r > `FSS_GAP_BIAS) ? (gap_r - `FSS_GAP_BIAS) : 16'h0001;
  assign fifo_push = rx_done_r & ~ctrl_r[`FSS_CTRL_RX_BLOCK];
  assign fifo_pop  = avs_read_i & acc_done & hit(avs_address_i, `FSS_OFF_RXDATA);
  fss_rx_fifo #(
    .WIDTH (8),
    .AW    (FIFO_AW)
  ) u_rx_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .push_i      (fifo_push),
    .push_data_i (rx_shift_r),
    .pop_i       (fifo_pop),
    .pop_data_o  (fifo_data),
    .full_o      (fifo_full),
    .empty_o     (fifo_empty)
  );
  always @* begin
    rd_nxt = 32'h0000_0000;
    case (1'b1)
      hit(avs_address_i, `FSS_OFF_CTRL):     rd_nxt[2:0]  = ctrl_r;
      hit(avs_address_i, `FSS_OFF_DIVISOR):  rd_nxt[15:0] = div_r;
      hit(avs_address_i, `FSS_OFF_GAP):      rd_nxt[15:0] = gap_r;
      hit(avs_address_i, `FSS_OFF_BLK_ADDR): rd_nxt[15:0] = blk_addr_r;
      hit(avs_address_i, `FSS_OFF_IRQ_STAT): rd_nxt[3:0]  = irq_stat_r;
      hit(avs_address_i, `FSS_OFF_IRQ_MASK): rd_nxt[3:0]  = irq_mask_r;
      hit(avs_address_i, `FSS_OFF_RXDATA):   rd_nxt[7:0]  = fifo_empty ? 8'h00 : fifo_data;
      hit(avs_address_i, `FSS_OFF_STATUS): begin
        rd_nxt[`FSS_ST_RX_AVAIL] = ~fifo_empty;
        rd_nxt[`FSS_ST_TX_BUSY]  = (tx_state_r != T_IDLE);
        rd_nxt[`FSS_ST_TX_PEND]  = tx_pend_r;
      end
      default: rd_nxt = 32'h0000_0000;
    endcase
  end
  always @* begin
    ev_nxt[`FSS_EV_RX_DONE]   = rx_done_r;
    ev_nxt[`FSS_EV_TX_DONE]   = tx_done_r;
    ev_nxt[`FSS_EV_RX_OVFL]   = fifo_push & fifo_full;
    ev_nxt[`FSS_EV_FRAME_ERR] = rx_ferr_r;
  end
  // bus slave and control registers
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h0000_0000;
      ctrl_r            <= `FSS_CTRL_RST;
      div_r             <= `FSS_DIVISOR_RST;
      gap_r             <= `FSS_GAP_RST;
      blk_addr_r        <= 16'h0000;
      irq_mask_r        <= 4'h0;
      irq_o             <= 1'b0;
    end else begin
      if ((avs_read_i | avs_write_i) & avs_waitrequest_o) begin
        avs_waitrequest_o <= 1'b0;
        avs_readdata_o    <= rd_nxt;
      end else begin
        avs_waitrequest_o <= 1'b1;
      end
      irq_o <= |(irq_stat_r & irq_mask_r);
      if (wr_done & hit(avs_address_i, `FSS_OFF_CTRL) & wbe[0]) begin
        ctrl_r <= wlo[2:0];
      end
      if (wr_done & hit(avs_address_i, `FSS_OFF_DIVISOR)) begin
        div_r <= merge16(div_r, wlo, wbe);
      end
      if (wr_done & hit(avs_address_i, `FSS_OFF_GAP)) begin
        gap_r <= merge16(gap_r, wlo, wbe);
      end
      if (wr_done & hit(avs_address_i, `FSS_OFF_IRQ_MASK) & wbe[0]) begin
        irq_mask_r <= wlo[3:0];
      end
      if (wr_done & hit(avs_address_i, `FSS_OFF_BLK_ADDR)) begin
        blk_addr_r <= merge16(blk_addr_r, wlo, wbe);
      end else if (rx_done_r & ctrl_r[`FSS_CTRL_RX_BLOCK]) begin
        blk_addr_r <= blk_addr_r + 16'h0001;
      end
    end
  end
  // sticky event bits, write one to clear, set wins
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_irq
      always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          irq_stat_r[gi] <= 1'b0;
        end else if (ev_nxt[gi]) begin
          irq_stat_r[gi] <= 1'b1;
        end else if (wr_done & hit(avs_address_i, `FSS_OFF_IRQ_STAT) & wbe[0] & wlo[gi]) begin
          irq_stat_r[gi] <= 1'b0;
        end
      end
    end
  endgenerate
  // block mode memory write port
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mem_wr_o    <= 1'b0;
      mem_addr_o  <= 16'h0000;
      mem_wdata_o <= 8'h00;
    end else begin
      mem_wr_o <= rx_done_r & ctrl_r[`FSS_CTRL_RX_BLOCK];
      if (rx_done_r & ctrl_r[`FSS_CTRL_RX_BLOCK]) begin
        mem_addr_o  <= blk_addr_r;
        mem_wdata_o <= rx_shift_r;
      end
    end
  end
  // transmitter
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_state_r            <= T_IDLE;
      tx_cnt_r              <= 16'h0000;
      tx_bit_r              <= 4'h0;
      tx_stop_r             <= 16'h0000;
      tx_shift_r            <= 8'h00;
      tx_hold_r             <= 8'h00;
      tx_pend_r             <= 1'b0;
      tx_done_r             <= 1'b0;
      serial_tx_line_o      <= 1'b1;
      request_to_send_out_o <= 1'b0;
    end else begin
      tx_done_r <= 1'b0;
      if (wr_done & hit(avs_address_i, `FSS_OFF_TXDATA) & wbe[0] & ~tx_pend_r) begin
        tx_hold_r <= wlo[7:0];
        tx_pend_r <= 1'b1;
      end
      tx_cnt_r <= tx_tick ? div_r : tx_cnt_r - 16'h0001;
      case (tx_state_r)
        T_IDLE: begin
          serial_tx_line_o <= 1'b1;
          if (tx_pend_r) begin
            tx_shift_r            <= tx_hold_r;
            tx_pend_r             <= 1'b0;
            request_to_send_out_o <= 1'b1;
            tx_state_r            <= T_WAIT;
          end
        end
        T_WAIT: begin
          if (~ctrl_r[`FSS_CTRL_FLOW_EN] | clear_to_send_in_i) begin
            serial_tx_line_o <= 1'b0;
            tx_cnt_r         <= div_r;
            tx_state_r       <= T_START;
          end
        end
        T_START: begin
          if (tx_tick) begin
            serial_tx_line_o <= tx_shift_r[0];
            tx_bit_r         <= 4'h0;
            tx_state_r       <= T_DATA;
          end
        end
        T_DATA: begin
          if (tx_bit_r == `FSS_RTS_DROP_BIT) begin
            request_to_send_out_o <= 1'b0;
          end
          if (tx_tick) begin
            if (tx_bit_r == `FSS_DATA_BITS - 4'h1) begin
              serial_tx_line_o <= 1'b1;
              tx_stop_r <= ctrl_r[`FSS_CTRL_TX_BLOCK] ? blk_stop : 16'h0001;
              tx_state_r <= T_STOP;
            end else begin
              serial_tx_line_o <= tx_shift_r[tx_bit_r[2:0] + 3'h1];
              tx_bit_r         <= tx_bit_r + 4'h1;
            end
          end
        end
        T_STOP: begin
          if (tx_tick) begin
            if (tx_stop_r == 16'h0001) begin
              tx_done_r  <= 1'b1;
              tx_state_r <= T_IDLE;
            end else begin
              tx_stop_r <= tx_stop_r - 16'h0001;
            end
          end
        end
        default: tx_state_r <= T_IDLE;
      endcase
    end
  end
  // receiver, mid-bit sampling
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_s1_r    <= 1'b1;
      rx_s2_r    <= 1'b1;
      rx_s3_r    <= 1'b1;
      rx_state_r <= R_IDLE;
      rx_cnt_r   <= 16'h0000;
      rx_bit_r   <= 4'h0;
      rx_shift_r <= 8'h00;
      rx_done_r  <= 1'b0;
      rx_ferr_r  <= 1'b0;
    end else begin
      rx_s1_r   <= serial_rx_line_i;
      rx_s2_r   <= rx_s1_r;
      rx_s3_r   <= rx_s2_r;
      rx_done_r <= 1'b0;
      rx_ferr_r <= 1'b0;
      rx_cnt_r  <= rx_tick ? div_r : rx_cnt_r - 16'h0001;
      case (rx_state_r)
        R_IDLE: begin
          if (rx_s3_r & ~rx_s2_r) begin
            rx_cnt_r   <= {1'b0, div_r[15:1]};
            rx_state_r <= R_START;
          end
        end
        R_START: begin
          if (rx_tick) begin
            rx_bit_r   <= 4'h0;
            rx_state_r <= rx_s2_r ? R_IDLE : R_DATA;
          end
        end
        R_DATA: begin
          if (rx_tick) begin
            rx_shift_r <= {rx_s2_r, rx_shift_r[7:1]};
            rx_bit_r   <= rx_bit_r + 4'h1;
            if (rx_bit_r == `FSS_DATA_BITS - 4'h1) begin
              rx_state_r <= R_STOP;
            end
          end
        end
        R_STOP: begin
          if (rx_tick) begin
            rx_done_r  <= rx_s2_r;
            rx_ferr_r  <= ~rx_s2_r;
            rx_state_r <= R_IDLE;
          end
        end
        default: rx_state_r <= R_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// [fss_serial_port_props.sv]
// assertion checker for the fast serial port top
`timescale 1ns/1ps
`default_nettype none
`include "fss_defines.vh"
module fss_serial_port_chk #(
  parameter FIFO_AW = 4
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic [15:0] avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic        irq_o,
  input wire logic        serial_tx_line_o,
  input wire logic        request_to_send_out_o,
  input wire logic        mem_wr_o
);
  logic       tx_q_r;
  logic [7:0] cnt_r;
  wire        start_w = tx_q_r & ~serial_tx_line_o & (cnt_r == 8'h00);
  // frame counter spans start plus eight data bits at reset rate
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_q_r <= 1'b1;
      cnt_r  <= 8'h00;
    end else begin
      tx_q_r <= serial_tx_line_o;
      cnt_r  <= start_w ? 8'hD8 : (cnt_r != 8'h00) ? cnt_r - 8'h01 : 8'h00;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_wait_one: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low longer than one cycle");
  chk_wait_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o) else $error("access not answered next cycle");
  chk_unmapped_zero: assert property (avs_read_i && !avs_waitrequest_o
    && avs_address_i == 16'hC0F0 |-> avs_readdata_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  chk_irq_masked: assert property (avs_write_i && !avs_waitrequest_o
    && avs_address_i == `FSS_OFF_IRQ_MASK && avs_writedata_i[3:0] == 4'h0
    |-> ##2 !irq_o) else $error("irq high with all masked");
  chk_start_len: assert property (start_w |-> (!serial_tx_line_o)[*8] ##16 !serial_tx_line_o)
    else $error("start bit too short");
  chk_rts_drop: assert property (start_w |-> ##[72:96] $fell(request_to_send_out_o))
    else $error("rts not dropped in third data bit");
  chk_mem_pulse: assert property (mem_wr_o |=> !mem_wr_o)
    else $error("memory write longer than one cycle");
  chk_idle_high: assert property (cnt_r == 8'h00 && !request_to_send_out_o
    |-> serial_tx_line_o) else $error("tx line not idle high");
endmodule
bind fss_serial_port fss_serial_port_chk #(.FIFO_AW(FIFO_AW)) i_chk (
  .clk_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
  .avs_readdata_o, .avs_waitrequest_o, .irq_o, .serial_tx_line_o,
  .request_to_send_out_o, .mem_wr_o
);
`default_nettype wire

// [fss_far_end.sv]
// far-end serial partner: frame decoder, sender, clear-to-send hold
`timescale 1ns/1ps
`default_nettype none
module fss_far_end #(
  parameter int P = 24
) (
  input  wire logic clk_i,
  input  wire logic tx_i,
  input  wire logic hold_i,
  output var  logic rx_o,
  output wire logic cts_o
);
  logic [7:0] got = 8'h00;
  int         nbytes = 0, gap = 0, cyc = 0, t0 = 0;
  initial rx_o = 1'b1;
  // hold only changes between frames, so cts stays high past rts fall
  assign cts_o = !hold_i;
  always @(posedge clk_i) cyc <= cyc + 1;
  always begin
    @(negedge tx_i);
    gap = cyc - t0 - 9 * P;
    t0 = cyc;
    repeat (P / 2) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (P) @(posedge clk_i);
      got[i] = tx_i;
    end
    nbytes++;
  end
  task automatic send(input logic [7:0] b, input int p, input logic stp = 1'b1);
    logic [9:0] f;
    f = {stp, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rx_o <= f[i];
      repeat (p) @(posedge clk_i);
    end
    // a broken stop level is followed by one idle period
    if (!stp) begin
      rx_o <= 1'b1;
      repeat (p) @(posedge clk_i);
    end
  endtask
endmodule
`default_nettype wire

// [tb_high_speed_serial_port.sv]
// self-checking bench for the fast serial port
`timescale 1ns/1ps
`default_nettype none
`include "fss_defines.vh"
module tb_high_speed_serial_port;
  localparam int P = 24;
  typedef struct { logic [7:0] b; int p; } fss_row_t;
  fss_row_t    rows [5] = '{'{8'h55, 24}, '{8'hA3, 25}, '{8'h0F, 23}, '{8'hFF, 24}, '{8'h80, 24}};
  logic        clk_i = 0, rst_i = 1, avs_read_i = 0, avs_write_i = 0, hold = 1;
  logic [15:0] avs_address_i = 0, mem_addr_o, mem_a;
  logic [31:0] avs_writedata_i = 0, avs_readdata_o, q;
  logic [7:0]  mem_wdata_o, mem_d;
  logic        avs_waitrequest_o, irq_o, serial_rx_line_i, serial_tx_line_o;
  logic        clear_to_send_in_i, request_to_send_out_o, mem_wr_o;
  int          failures = 0, num_checks = 0, n0;
  always #2.5 clk_i = ~clk_i;
  fss_serial_port i_dut (.clk_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_byteenable_i(4'hF), .avs_readdata_o, .avs_waitrequest_o, .irq_o,
    .serial_rx_line_i, .serial_tx_line_o, .clear_to_send_in_i, .request_to_send_out_o,
    .mem_wr_o, .mem_addr_o, .mem_wdata_o);
  fss_far_end #(.P(P)) i_far (.clk_i, .tx_i(serial_tx_line_o), .hold_i(hold),
    .rx_o(serial_rx_line_i), .cts_o(clear_to_send_in_i));
  always @(posedge clk_i) begin
    if (mem_wr_o === 1'b1) begin
      mem_a <= mem_addr_o;
      mem_d <= mem_wdata_o;
    end
  end
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
    avs_write_i <= w;
    avs_read_i <= !w;
    avs_address_i <= a;
    avs_writedata_i <= d;
    do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rdc(input string nm, input logic [15:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(nm, q, e);
  endtask
  task automatic pair(input logic [7:0] a, input logic [7:0] b, input int s);
    // wait for an idle transmitter so both bytes are accepted
    do bus(1'b0, `FSS_OFF_STATUS, 32'h0000_0000); while (q[2:1] != 2'b00);
    n0 = i_far.nbytes;
    bus(1'b1, `FSS_OFF_TXDATA, {24'h00_0000, a});
    bus(1'b1, `FSS_OFF_TXDATA, {24'h00_0000, b});
    rdc("txst", `FSS_OFF_STATUS, 32'h0000_0006);
    while (i_far.nbytes < n0 + 1) @(posedge clk_i);
    chk("tx1", i_far.got, a);
    while (i_far.nbytes < n0 + 2) @(posedge clk_i);
    chk("tx2", i_far.got, b);
    chk("stop", i_far.gap / P, s);
  endtask
  task automatic final_report;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk_i);
    failures++;
    final_report();
  end
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdc("gap", `FSS_OFF_GAP, 32'h0000_000B);
    rdc("div", `FSS_OFF_DIVISOR, 32'h0000_0017);
    rdc("unmapped", 16'hC0F0, 32'h0000_0000);
    foreach (rows[i]) begin
      i_far.send(rows[i].b, rows[i].p);
      repeat (4) @(posedge clk_i);
      rdc("avail", `FSS_OFF_STATUS, 32'h0000_0001);
      rdc("rxbyte", `FSS_OFF_RXDATA, {24'h00_0000, rows[i].b});
      rdc("empty", `FSS_OFF_STATUS, 32'h0000_0000);
    end
    pair(8'hA5, 8'h3C, 1);
    bus(1'b1, `FSS_OFF_CTRL, 32'h0000_0002);
    pair(8'h5A, 8'hC3, 2);
    bus(1'b1, `FSS_OFF_GAP, 32'h0000_000D);
    pair(8'h01, 8'h80, 4);
    bus(1'b1, `FSS_OFF_CTRL, 32'h0000_0001);
    n0 = i_far.nbytes;
    bus(1'b1, `FSS_OFF_TXDATA, 32'h0000_0096);
    repeat (40) @(posedge clk_i);
    chk("held", {request_to_send_out_o, serial_tx_line_o}, 2'b11);
    hold <= 1'b0;
    while (i_far.nbytes < n0 + 1) @(posedge clk_i);
    chk("flow", i_far.got, 8'h96);
    bus(1'b1, `FSS_OFF_IRQ_MASK, 32'h0000_0001);
    bus(1'b1, `FSS_OFF_CTRL, 32'h0000_0004);
    bus(1'b1, `FSS_OFF_BLK_ADDR, 32'h0000_0120);
    for (int i = 0; i < 2; i++) begin
      i_far.send(8'h6B + i[7:0], P);
      chk("memaddr", mem_a, 16'h0120 + i[15:0]);
      chk("memdata", mem_d, 8'h6B + i[7:0]);
    end
    rdc("nofifo", `FSS_OFF_STATUS, 32'h0000_0000);
    chk("irq", irq_o, 1'b1);
    bus(1'b1, `FSS_OFF_IRQ_MASK, 32'h0000_0000);
    @(posedge clk_i);
    chk("irqmask", irq_o, 1'b0);
    bus(1'b1, `FSS_OFF_IRQ_MASK, 32'h0000_0001);
    @(posedge clk_i);
    chk("irqon", irq_o, 1'b1);
    bus(1'b1, `FSS_OFF_IRQ_STAT, 32'h0000_000F);
    @(posedge clk_i);
    chk("irqclr", irq_o, 1'b0);
    bus(1'b1, `FSS_OFF_IRQ_MASK, 32'h0000_0008);
    i_far.send(8'h00, P, 1'b0);
    chk("ferr", irq_o, 1'b1);
    rdc("ferrst", `FSS_OFF_IRQ_STAT, 32'h0000_0008);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk("rst", {irq_o, request_to_send_out_o, serial_tx_line_o}, 3'b001);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdc("gap2", `FSS_OFF_GAP, 32'h0000_000B);
    final_report();
  end
endmodule
`default_nettype wire
